// ### logic/uart_rx_pkg.sv
// Constants, register map and state encoding of the serial receive, error, interrupt and
// wake-up block.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
//
// Summary of operation
// - Receive buffer holds two whole words while a third is being shifted in.
// - Third word into a full buffer sets overrun, keeps buffer, may interrupt.
// - Overrun flag clears only after a status read then a buffer read.
// - Noisy word still stored; noise flag rises with data-available, no own interrupt.
// - Noise flag resets after a status read then a buffer read.
// - Low sampled at either expected stop bit sets the framing error flag.
// - Parity error flag set on wrong parity only while parity checking is enabled.
// - Framing and parity flags stored per word; software reads them before data.
// - Any enabled source gives a low interrupt pulse to the processor.
// - Each transmit source has its own enable; receive sources except address detect share one.
// - Address detect raises the interrupt without a flag, only when enabled.
// - Receive-pin wake-up raises the interrupt when wake and receive enables set.
// - Status flags are read-only and clear only through hardware access sequences.
// - With address detect on, data interrupt only when the top received bit is one.
// - With address detect off, every new word requests a data interrupt.
// - With the clock stopped, reception in progress pauses and later resumes.
// - Power down leaves status, control, baud and data registers unchanged.
// - With all wake enables set, a falling receive edge wakes the system.
// - Receive data during start-up is ignored; wake interrupt waits for start-up end.
// - Wake interrupt needs global and module enables; otherwise wake only.
// - Data-available flag clears after a status read then a buffer read.

package uart_rx_pkg;

  // =========================================================
  // Register byte offsets
  localparam logic [7:0] STATUS_OFFS = 8'h00;
  localparam logic [7:0] CTRL1_OFFS = 8'h04;
  localparam logic [7:0] CTRL2_OFFS = 8'h08;
  localparam logic [7:0] BAUD_OFFS = 8'h0c;
  localparam logic [7:0] RXBUF_OFFS = 8'h10;

  // =========================================================
  // Control register one fields
  localparam int MOD_EN_BIT = 0;
  localparam int NINE_BIT = 1;
  localparam int PAR_EN_BIT = 2;
  localparam int PAR_ODD_BIT = 3;
  localparam int TWO_STOP_BIT = 4;
  localparam logic [7:0] CTRL1_MASK = 8'h1f;
  localparam logic [7:0] CTRL1_RESET = 8'h00;

  // Control register two fields
  localparam int RX_EN_BIT = 0;
  localparam int RIE_BIT = 1;
  localparam int ADDR_EN_BIT = 2;
  localparam int WAKE_EN_BIT = 3;
  localparam int TEIE_BIT = 4;
  localparam int TIIE_BIT = 5;
  localparam logic [7:0] CTRL2_MASK = 8'h3f;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;

  // Status register fields
  localparam int ST_AVAIL_BIT = 0;
  localparam int ST_OVR_BIT = 1;
  localparam int ST_NOISE_BIT = 2;
  localparam int ST_FRAME_ERR_FLAG_BIT = 3;
  localparam int ST_PARITY_ERR_FLAG_BIT = 4;
  localparam int ST_IDLE_BIT = 5;

  // Buffer entry layout: data in [8:0]
  localparam int ENT_NOISE_BIT = 9;
  localparam int ENT_FRAME_ERR_FLAG_BIT = 10;
  localparam int ENT_PARITY_ERR_FLAG_BIT = 11;

  // =========================================================
  // Framing and timing
  localparam logic [3:0] SAMPLE_POINT = 4'h8;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STARTUP_NS = 1000;
  localparam int STARTUP_CYCLES_INT = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STARTUP_LAST = 8'(STARTUP_CYCLES_INT - 1);

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP1,
    RX_STOP2,
    RX_BREAK_WAIT
  } rx_state_t;

endpackage

// ### logic/rx_sample_if.sv
// Link between the receive frame logic and its oversampling majority sampler.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none

interface rx_sample_if;
  logic os_tick;
  logic rx_level;
  logic bit_value;
  logic bit_noise;

  modport frame (output os_tick, output rx_level, input bit_value, input bit_noise);
  modport sampler (input os_tick, input rx_level, output bit_value, output bit_noise);
endinterface

`default_nettype wire

// ### logic/rx_bit_sampler.sv
// Three-sample majority detector with noise indication.
// Assumes rx_level is already synchronised and os_tick is a one-cycle strobe.
`timescale 1ns/1ns
`default_nettype none

module rx_bit_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Sample link
  rx_sample_if.sampler bus
);
  typedef struct packed {
    logic [2:0] win;
    logic value;
    logic noise;
  } samp_t;

  samp_t samp_reg;
  samp_t samp_next;
  logic [2:0] w;

  always_comb
  begin
    samp_next = samp_reg;
    w = {samp_reg.win[1:0], bus.rx_level};
    if (bus.os_tick)
    begin
      samp_next.win = w;
      samp_next.value = (w[0] & w[1]) | (w[0] & w[2]) | (w[1] & w[2]);
      // Disagreeing samples mark noise
      samp_next.noise = (|w) & ~(&w);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      samp_reg <= '0;
    else
      samp_reg <= samp_next;
  end

  assign bus.bit_value = samp_reg.value;
  assign bus.bit_noise = samp_reg.noise;
endmodule

`default_nettype wire

// ### logic/uart_rx_errors_irq_wakeup.sv
// Serial receiver with two-word buffer, error flags, interrupt pulse and pin wake-up.
// Assumes an APB master on clk, a transmitter that reports its flags on clk,
// and a system that gates clk or raises power_down while asleep.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module uart_rx_errors_irq_wakeup (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rx_pin,
  // Transmitter flags
  input wire logic tx_buf_empty,
  input wire logic tx_idle,
  // System control
  input wire logic power_down,
  input wire logic global_irq_enable,
  input wire logic serial_irq_enable,
  // Interrupt and wake-up
  output logic irq_n,
  output logic wake_req
);
  typedef struct packed {
    logic rx_low_meta;
    logic rx_low_sync;
    logic rx_low_prev;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] baud;
    logic [7:0] div;
    logic [3:0] os_cnt;
    uart_rx_pkg::rx_state_t state;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic par_acc;
    logic noise_acc;
    logic frame_err_flag_acc;
    logic [1:0][11:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic overrun;
    logic armed;
    logic ack;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    logic wake;
    logic starting;
    logic [7:0] startup;
    logic txe_prev;
    logic txi_prev;
  } state_t;

  state_t st_reg;
  state_t st_next;
  rx_sample_if smp();

  logic acc, done, rd_buf, clear_seq, avail, run, os_tick, sample;
  logic mod_en, rx_en, rx_irq_enable, addr_en, wake_en, nine, par_en, two_stop;
  logic word_done, word_msb, fin_frame_err_flag, fin_parity_err_flag, push, pop, ovr_ev;
  logic rx_ev, addr_ev, other_ev, wake_irq_ev, fall_edge, v;
  logic [11:0] head;
  logic [8:0] word_data;
  logic [3:0] last_bit;

  rx_bit_sampler u_sampler (
    .clk(clk),
    .nrst(nrst),
    .bus(smp.sampler)
  );

  assign smp.os_tick = os_tick;
  assign smp.rx_level = ~st_reg.rx_low_sync;

  // =========================================================
  // Next-state logic
  always_comb
  begin
    st_next = st_reg;
    acc = psel & penable & ~st_reg.ack;
    done = psel & penable & st_reg.ack;
    avail = (st_reg.count != 2'h0);
    head = st_reg.mem[st_reg.rd_ptr];
    rd_buf = done & ~pwrite & (paddr == uart_rx_pkg::RXBUF_OFFS);
    clear_seq = rd_buf & st_reg.armed;
    mod_en = st_reg.ctrl1[uart_rx_pkg::MOD_EN_BIT];
    nine = st_reg.ctrl1[uart_rx_pkg::NINE_BIT];
    par_en = st_reg.ctrl1[uart_rx_pkg::PAR_EN_BIT];
    two_stop = st_reg.ctrl1[uart_rx_pkg::TWO_STOP_BIT];
    rx_en = st_reg.ctrl2[uart_rx_pkg::RX_EN_BIT];
    rx_irq_enable = st_reg.ctrl2[uart_rx_pkg::RIE_BIT];
    addr_en = st_reg.ctrl2[uart_rx_pkg::ADDR_EN_BIT];
    wake_en = st_reg.ctrl2[uart_rx_pkg::WAKE_EN_BIT];
    last_bit = nine ? uart_rx_pkg::LAST_BIT_9 : uart_rx_pkg::LAST_BIT_8;
    fall_edge = st_reg.rx_low_sync & ~st_reg.rx_low_prev;
    // Paused while asleep, held idle while the system restarts
    run = mod_en & rx_en & ~power_down & ~st_reg.starting;
    v = smp.bit_value;
    os_tick = 1'b0;
    sample = 1'b0;
    word_done = 1'b0;
    fin_frame_err_flag = st_reg.frame_err_flag_acc;
    // Parity sum over data and parity bit is odd for odd parity
    fin_parity_err_flag = par_en & (st_reg.par_acc ^ st_reg.ctrl1[uart_rx_pkg::PAR_ODD_BIT]);
    // The top received bit sits in shift[8] for both word lengths
    word_msb = st_reg.shift[8];
    word_data = nine ? st_reg.shift : {1'b0, st_reg.shift[8:1]};
    push = 1'b0;
    pop = 1'b0;
    ovr_ev = 1'b0;
    wake_irq_ev = 1'b0;

    st_next.rx_low_meta = ~rx_pin;
    st_next.rx_low_sync = st_reg.rx_low_meta;
    st_next.rx_low_prev = st_reg.rx_low_sync;
    st_next.txe_prev = tx_buf_empty;
    st_next.txi_prev = tx_idle;

    // =======================================================
    // Baud divider, sixteen ticks per bit
    if (run)
    begin
      if (st_reg.div >= st_reg.baud)
      begin
        st_next.div = 8'h00;
        os_tick = 1'b1;
      end
      else
        st_next.div = st_reg.div + 8'h01;
    end

    // =======================================================
    // Frame receiver
    if (run && st_reg.state != uart_rx_pkg::RX_IDLE && os_tick)
    begin
      st_next.os_cnt = st_reg.os_cnt + 4'h1;
      sample = (st_reg.os_cnt == uart_rx_pkg::SAMPLE_POINT);
    end
    if (st_reg.starting || !mod_en || !rx_en)
      st_next.state = uart_rx_pkg::RX_IDLE;
    else if (run)
    begin
      case (st_reg.state)
        uart_rx_pkg::RX_IDLE:
        begin
          if (st_reg.rx_low_sync)
          begin
            st_next.state = uart_rx_pkg::RX_START;
            st_next.os_cnt = 4'h0;
            st_next.bit_cnt = 4'h0;
            st_next.par_acc = 1'b0;
            st_next.noise_acc = 1'b0;
            st_next.frame_err_flag_acc = 1'b0;
          end
        end
        uart_rx_pkg::RX_START:
        begin
          if (sample)
          begin
            st_next.noise_acc = smp.bit_noise;
            st_next.state = v ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
          end
        end
        uart_rx_pkg::RX_DATA:
        begin
          if (sample)
          begin
            st_next.shift = {v, st_reg.shift[8:1]};
            st_next.par_acc = st_reg.par_acc ^ v;
            st_next.noise_acc = st_reg.noise_acc | smp.bit_noise;
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            if (st_reg.bit_cnt == last_bit)
              st_next.state = par_en ? uart_rx_pkg::RX_PARITY : uart_rx_pkg::RX_STOP1;
          end
        end
        uart_rx_pkg::RX_PARITY:
        begin
          if (sample)
          begin
            st_next.par_acc = st_reg.par_acc ^ v;
            st_next.noise_acc = st_reg.noise_acc | smp.bit_noise;
            st_next.state = uart_rx_pkg::RX_STOP1;
          end
        end
        uart_rx_pkg::RX_STOP1, uart_rx_pkg::RX_STOP2:
        begin
          if (sample)
          begin
            // Either stop bit low is a framing error
            fin_frame_err_flag = st_reg.frame_err_flag_acc | ~v;
            st_next.noise_acc = st_reg.noise_acc | smp.bit_noise;
            if (st_reg.state == uart_rx_pkg::RX_STOP1 && two_stop)
            begin
              st_next.frame_err_flag_acc = fin_frame_err_flag;
              st_next.state = uart_rx_pkg::RX_STOP2;
            end
            else
            begin
              word_done = 1'b1;
              // After a break wait for the line to return high
              st_next.state = fin_frame_err_flag ? uart_rx_pkg::RX_BREAK_WAIT : uart_rx_pkg::RX_IDLE;
            end
          end
        end
        uart_rx_pkg::RX_BREAK_WAIT:
        begin
          if (!st_reg.rx_low_sync)
            st_next.state = uart_rx_pkg::RX_IDLE;
        end
        default:
          st_next.state = uart_rx_pkg::RX_IDLE;
      endcase
    end

    // =======================================================
    // Two-word buffer with per-word error flags
    if (word_done)
    begin
      if (st_reg.count == uart_rx_pkg::FIFO_DEPTH && !rd_buf)
        ovr_ev = 1'b1;
      else
      begin
        push = 1'b1;
        st_next.mem[st_reg.wr_ptr] = {fin_parity_err_flag, fin_frame_err_flag, st_reg.noise_acc | smp.bit_noise,
                                      word_data};
        st_next.wr_ptr = ~st_reg.wr_ptr;
      end
    end
    if (rd_buf && avail)
    begin
      pop = 1'b1;
      st_next.rd_ptr = ~st_reg.rd_ptr;
    end
    case ({push, pop})
      2'b10: st_next.count = st_reg.count + 2'h1;
      2'b01: st_next.count = st_reg.count - 2'h1;
      default: st_next.count = st_reg.count;
    endcase
    // A buffer read in the same cycle frees a slot, so no new overrun rises and the clear wins
    st_next.overrun = ovr_ev | (st_reg.overrun & ~clear_seq);
    if (done && !pwrite && paddr == uart_rx_pkg::STATUS_OFFS)
      st_next.armed = 1'b1;
    else if (rd_buf)
      st_next.armed = 1'b0;

    // =======================================================
    // Power-down wake-up and start-up delay
    st_next.wake = 1'b0;
    if (st_reg.starting)
    begin
      if (st_reg.startup == uart_rx_pkg::STARTUP_LAST)
      begin
        st_next.starting = 1'b0;
        // Interrupt only after start-up and only with system enables
        wake_irq_ev = wake_en & rx_irq_enable & global_irq_enable & serial_irq_enable;
      end
      else
        st_next.startup = st_reg.startup + 8'h01;
    end
    else if (power_down && wake_en && mod_en && rx_en && rx_irq_enable && fall_edge)
    begin
      st_next.wake = 1'b1;
      st_next.starting = 1'b1;
      st_next.startup = 8'h00;
    end

    // =======================================================
    // Interrupt sources
    rx_ev = push & rx_irq_enable & (~addr_en | word_msb);
    addr_ev = word_done & addr_en & word_msb;
    other_ev = (ovr_ev & rx_irq_enable)
             | (tx_buf_empty & ~st_reg.txe_prev & st_reg.ctrl2[uart_rx_pkg::TEIE_BIT])
             | (tx_idle & ~st_reg.txi_prev & st_reg.ctrl2[uart_rx_pkg::TIIE_BIT])
             | addr_ev | wake_irq_ev;
    st_next.irq = rx_ev | other_ev;

    // =======================================================
    // APB: one wait state, side effects at the completing edge
    st_next.ack = acc;
    if (acc)
    begin
      st_next.pslverr = 1'b0;
      st_next.prdata = 32'h0000_0000;
      case (paddr)
        uart_rx_pkg::STATUS_OFFS:
        begin
          st_next.prdata[uart_rx_pkg::ST_AVAIL_BIT] = avail;
          st_next.prdata[uart_rx_pkg::ST_OVR_BIT] = st_reg.overrun;
          st_next.prdata[uart_rx_pkg::ST_NOISE_BIT] = avail & head[uart_rx_pkg::ENT_NOISE_BIT];
          st_next.prdata[uart_rx_pkg::ST_FRAME_ERR_FLAG_BIT] = avail & head[uart_rx_pkg::ENT_FRAME_ERR_FLAG_BIT];
          st_next.prdata[uart_rx_pkg::ST_PARITY_ERR_FLAG_BIT] = avail & head[uart_rx_pkg::ENT_PARITY_ERR_FLAG_BIT];
          st_next.prdata[uart_rx_pkg::ST_IDLE_BIT] = (st_reg.state == uart_rx_pkg::RX_IDLE);
        end
        uart_rx_pkg::CTRL1_OFFS: st_next.prdata[7:0] = st_reg.ctrl1;
        uart_rx_pkg::CTRL2_OFFS: st_next.prdata[7:0] = st_reg.ctrl2;
        uart_rx_pkg::BAUD_OFFS: st_next.prdata[7:0] = st_reg.baud;
        uart_rx_pkg::RXBUF_OFFS: st_next.prdata[8:0] = avail ? head[8:0] : 9'h000;
        default: st_next.pslverr = 1'b1;
      endcase
    end
    // Status and buffer are read-only; power_down never touches these
    if (done && pwrite && pstrb[0])
    begin
      case (paddr)
        uart_rx_pkg::CTRL1_OFFS: st_next.ctrl1 = pwdata[7:0] & uart_rx_pkg::CTRL1_MASK;
        uart_rx_pkg::CTRL2_OFFS: st_next.ctrl2 = pwdata[7:0] & uart_rx_pkg::CTRL2_MASK;
        uart_rx_pkg::BAUD_OFFS: st_next.baud = pwdata[7:0];
        default: st_next.baud = st_reg.baud;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign prdata = st_reg.prdata;
  assign pready = done;
  assign pslverr = st_reg.pslverr;
  assign irq_n = ~st_reg.irq;
  assign wake_req = st_reg.wake;

  // =========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence seq_word_into_full;
    word_done && st_reg.count == 2'h2 && !rd_buf;
  endsequence

  sequence seq_wake_start;
    st_reg.wake ##1 st_reg.starting;
  endsequence

  AST_FIFO_DEPTH: assert property (push |-> st_reg.count < 2'h2 || pop)
    else $error("push into a full receive buffer");
  AST_OVERRUN_KEEPS: assert property (seq_word_into_full |=>
    st_reg.overrun && st_reg.count == 2'h2 && $stable(st_reg.mem))
    else $error("overrun lost or disturbed buffered words");
  AST_OVR_STICKY: assert property (st_reg.overrun && !clear_seq |=> st_reg.overrun)
    else $error("overrun cleared without the read sequence");
  AST_OVR_CLEAR: assert property (clear_seq && !ovr_ev |=> !st_reg.overrun)
    else $error("overrun not cleared by the read sequence");
  AST_FRAME_ERR_FLAG: assert property ((st_reg.state == uart_rx_pkg::RX_STOP1
    || st_reg.state == uart_rx_pkg::RX_STOP2) && sample && !v |-> fin_frame_err_flag)
    else $error("low stop bit did not flag a framing error");
  AST_IRQ_PULSE: assert property ((rx_ev || other_ev) |=> !irq_n)
    else $error("interrupt event gave no low pulse");
  AST_ADDR_QUAL: assert property (push && addr_en && !word_msb && !other_ev |=> irq_n)
    else $error("data interrupt without the top bit in address mode");
  AST_WAKE_DELAY: assert property (seq_wake_start |-> !wake_irq_ev [*8])
    else $error("wake interrupt before start-up elapsed");
  AST_STARTUP_IDLE: assert property (st_reg.starting |=> st_reg.state == uart_rx_pkg::RX_IDLE)
    else $error("receiver active during start-up");
  AST_PAUSE: assert property (power_down && !st_reg.starting |=>
    $stable(st_reg.state) && $stable(st_reg.shift))
    else $error("receiver moved while powered down");
endmodule

`default_nettype wire

// ### tb/serial_tx_model.sv
// Remote serial transmitter that drives the receive line of the block.
// Assumes the baud register holds 0, so one bit lasts 16 system clocks.
`timescale 1ns/1ns
`default_nettype none

module serial_tx_model (
  // Clock
  input wire logic clk,
  // Serial line
  output var logic line
);
  initial line = 1'b1;

  // ==========================================
  // Bit and frame drivers
  // One bit time, with an optional one-clock glitch at mid-bit
  task automatic bit_out(input logic v, input logic glitch);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      line <= (glitch && i == 8) ? !v : v;
    end
  endtask

  // par: [0] sends a parity bit, [1] is its value; stops: first and second stop slot
  task automatic send(input logic [8:0] d, input int nb, input logic [1:0] par,
    input logic [1:0] stops, input logic noise);
    bit_out(1'b0, 1'b0);
    for (int i = 0; i < nb; i++)
      bit_out(d[i], noise && i == 0);
    if (par[0])
      bit_out(par[1], 1'b0);
    bit_out(stops[0], 1'b0);
    bit_out(stops[1], 1'b0);
    bit_out(1'b1, 1'b0);
  endtask
endmodule

`default_nettype wire

// ### tb/test_uart_rx_errors_irq_wakeup.sv
// Self-checking bench for the serial receiver, error flags, interrupt and wake-up.
// Assumes the serial transmitter model and a one-wait-state APB slave.
`timescale 1ns/1ns
`default_nettype none

module test_uart_rx_errors_irq_wakeup;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, rx_pin, serr;
  logic tx_buf_empty, tx_idle, power_down, global_irq_enable, serial_irq_enable;
  logic irq_n, wake_req;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rd;
  int miscompares, num_checks, irqs, wakes, n, w;

  uart_rx_errors_irq_wakeup dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_buf_empty(tx_buf_empty),
    .tx_idle(tx_idle), .power_down(power_down), .global_irq_enable(global_irq_enable),
    .serial_irq_enable(serial_irq_enable), .irq_n(irq_n), .wake_req(wake_req));
  serial_tx_model tx (.clk(clk), .line(rx_pin));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge irq_n) irqs++;
  always @(posedge wake_req) wakes++;

  // ==========================================
  // Reporting
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Status word: idle high plus {parity, frame, noise, overrun, available}
  function automatic logic [31:0] st(input logic [4:0] f);
    st = {26'h0, 1'b1, f};
  endfunction

  // ==========================================
  // APB master
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      $display("[ERR] %0t bus wait timed out", $time);
      miscompares++;
      wrap_up();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic stat(input logic [31:0] exp);
    rdx(uart_rx_pkg::STATUS_OFFS, exp);
  endtask

  task automatic pop(input logic [31:0] exp);
    rdx(uart_rx_pkg::RXBUF_OFFS, exp);
  endtask

  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2);
    apb(1'b1, uart_rx_pkg::CTRL1_OFFS, 32'(c1));
    apb(1'b1, uart_rx_pkg::CTRL2_OFFS, 32'(c2));
  endtask

  task automatic send8(input logic [8:0] d, input logic noise);
    tx.send(d, 8, 2'b00, 2'b11, noise);
  endtask

  task automatic txev(input logic sel, input int exp);
    n = irqs;
    @(posedge clk);
    tx_buf_empty <= !sel;
    tx_idle <= sel;
    repeat (4) @(posedge clk);
    tx_buf_empty <= 1'b0;
    tx_idle <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(irqs - n), 32'(exp));
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    rdx(uart_rx_pkg::CTRL1_OFFS, 32'(uart_rx_pkg::CTRL1_RESET));
    rdx(uart_rx_pkg::CTRL2_OFFS, 32'(uart_rx_pkg::CTRL2_RESET));
    rdx(uart_rx_pkg::BAUD_OFFS, 32'(uart_rx_pkg::BAUD_RESET));
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, serr}, 32'h1);
    apb(1'b1, uart_rx_pkg::BAUD_OFFS, 32'h0);
    cfg(8'h01, 8'h03);
    apb(1'b1, uart_rx_pkg::STATUS_OFFS, 32'h1f);
    stat(st(5'h00));
    $display("test regs done");
  endtask

  task automatic t_basic();
    n = irqs;
    send8(9'h0a5, 1'b0);
    chk(32'(irqs - n), 32'h1);
    stat(st(5'h01));
    pop(32'h0a5);
    stat(st(5'h00));
    pop(32'h000);
    n = irqs;
    send8(9'h011, 1'b0);
    send8(9'h022, 1'b0);
    send8(9'h033, 1'b0);
    chk(32'(irqs - n), 32'h3);
    pop(32'h011);
    stat(st(5'h03));
    pop(32'h022);
    stat(st(5'h00));
    $display("test receive and overrun done");
  endtask

  task automatic t_errors();
    cfg(8'h15, 8'h01);
    tx.send(9'h03c, 8, 2'b01, 2'b01, 1'b0);
    tx.send(9'h03c, 8, 2'b11, 2'b11, 1'b0);
    stat(st(5'h09));
    pop(32'h03c);
    stat(st(5'h11));
    pop(32'h03c);
    cfg(8'h0d, 8'h01);
    tx.send(9'h03c, 8, 2'b11, 2'b11, 1'b0);
    stat(st(5'h01));
    pop(32'h03c);
    cfg(8'h01, 8'h03);
    n = irqs;
    send8(9'h05a, 1'b1);
    chk(32'(irqs - n), 32'h1);
    stat(st(5'h05));
    pop(32'h05a);
    stat(st(5'h00));
    $display("test errors done");
  endtask

  task automatic t_addr();
    cfg(8'h01, 8'h05);
    n = irqs;
    send8(9'h005, 1'b0);
    chk(32'(irqs - n), 32'h0);
    send8(9'h085, 1'b0);
    chk(32'(irqs - n), 32'h1);
    pop(32'h005);
    pop(32'h085);
    cfg(8'h03, 8'h05);
    n = irqs;
    tx.send(9'h080, 9, 2'b00, 2'b11, 1'b0);
    chk(32'(irqs - n), 32'h0);
    tx.send(9'h100, 9, 2'b00, 2'b11, 1'b0);
    chk(32'(irqs - n), 32'h1);
    pop(32'h080);
    pop(32'h100);
    cfg(8'h01, 8'h10);
    txev(1'b0, 1);
    txev(1'b1, 0);
    cfg(8'h01, 8'h20);
    txev(1'b1, 1);
    txev(1'b0, 0);
    $display("test address and transmit sources done");
  endtask

  task automatic t_wake();
    cfg(8'h01, 8'h0b);
    for (int g = 1; g >= 0; g--)
    begin
      global_irq_enable <= 1'(g);
      @(posedge clk);
      power_down <= 1'b1;
      n = irqs;
      w = wakes;
      tx.bit_out(1'b0, 1'b0);
      power_down <= 1'b0;
      tx.bit_out(1'b1, 1'b0);
      chk(32'(wakes - w), 32'h1);
      chk(32'(irqs - n), 32'h0);
      repeat (100) @(posedge clk);
      chk(32'(irqs - n), 32'(g));
      stat(st(5'h00));
    end
    rdx(uart_rx_pkg::CTRL1_OFFS, 32'h01);
    rdx(uart_rx_pkg::CTRL2_OFFS, 32'h0b);
    $display("test wake done");
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    $display("[ERR] %0t run limit reached", $time);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    tx_buf_empty = 1'b0;
    tx_idle = 1'b0;
    power_down = 1'b0;
    global_irq_enable = 1'b1;
    serial_irq_enable = 1'b1;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_basic();
    t_errors();
    t_addr();
    t_wake();
    wrap_up();
  end
endmodule

`default_nettype wire
